// File: rsw_pkg.sv
// Package of constants and carrier types for the reset and sleep/wake sequencer
package rsw_pkg;

    // ************************************************************
    // Register bus offsets (byte addresses, one word each)
    // ************************************************************
    localparam logic [7:0] RSW_ADDR_STATUS      = 8'h00; // Status register
    localparam logic [7:0] RSW_ADDR_RAMSEL      = 8'h04; // RAM select register
    localparam logic [7:0] RSW_ADDR_CONTROL     = 8'h08; // Control options register
    localparam logic [7:0] RSW_ADDR_P6WAKE      = 8'h0C; // Port6 wake disable register
    localparam logic [7:0] RSW_ADDR_SLPWDT      = 8'h10; // Sleep/watchdog control register
    localparam logic [7:0] RSW_ADDR_INTFLAG     = 8'h14; // Interrupt flag register
    localparam logic [7:0] RSW_ADDR_INTMASK     = 8'h18; // Interrupt mask register
    localparam logic [7:0] RSW_ADDR_CMD         = 8'h1C; // Command: sleep op, watchdog clear
    localparam logic [7:0] RSW_ADDR_STATE       = 8'h20; // Sequencer state and program counter bits 10:8

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int RSW_ST_TIMEOUT   = 4;  // Status: timeout flag
    localparam int RSW_ST_PWRDN     = 3;  // Status: power-down flag
    localparam int RSW_SW_WDTE      = 5;  // Sleep/watchdog: watchdog enable
    localparam int RSW_SW_OSCRUN    = 4;  // Sleep/watchdog: oscillator run bit
    localparam int RSW_CMD_SLEEP    = 0;  // Command: enter sleep op
    localparam int RSW_CMD_WDCLR    = 1;  // Command: watchdog clear

    // ************************************************************
    // Reset values and masks
    // ************************************************************
    localparam logic [7:0] RSW_STATUS_POR_MASK = 8'h9F; // Keeps all but bits 5..6
    localparam logic [7:0] RSW_RAMSEL_POR_MASK = 8'h3F; // Keeps all but upper 2 bits
    localparam logic [7:0] RSW_CONTROL_RST     = 8'hBF; // All ones but bit 6
    localparam logic [7:0] RSW_P6WAKE_RST      = 8'hFF; // All wake disabled
    localparam logic [7:0] RSW_SLPWDT_CLR_MASK = 8'hB7; // Clears bits 3 and 6
    localparam logic [7:0] RSW_SLPWDT_SET_MASK = 8'h31; // Sets bits 0, 4, 5
    localparam logic [7:0] RSW_INT_CLR_MASK    = 8'hF6; // Clears bits 0 and 3
    localparam logic [10:0] RSW_PC_RST         = 11'h7FF; // Program counter all ones
    localparam logic [7:0] RSW_STATUS_POR      = 8'h18; // Status after power-on, both cause flags set

    // ************************************************************
    // Timing: start-up hold and watchdog tick
    // ************************************************************
    localparam int RSW_CLK_MHZ        = 200;  // Core clock rate
    localparam int RSW_OST_MS         = 18;   // Start-up hold time
    localparam int RSW_RC_TICK_NS     = 1000; // Watchdog RC tick period
    localparam int RSW_RC_DIV         = (RSW_RC_TICK_NS * RSW_CLK_MHZ) / 1000; // Clocks per RC tick
    localparam int RSW_OST_TICKS      = (RSW_OST_MS * 1000000) / RSW_RC_TICK_NS; // RC ticks per hold

    // ************************************************************
    // States
    // ************************************************************
    typedef enum logic [2:0] {
        RSW_S_HOLD   = 3'b000, // Core held in reset
        RSW_S_RUN    = 3'b001, // Normal execution
        RSW_S_HALT_UNTIL_RESET_MODE = 3'b010, // Halt until reset mode
        RSW_S_OSCILLATOR_STOP_RESUME_MODE = 3'b011, // Oscillator stop, resume mode
        RSW_S_OST    = 3'b100  // Start-up delay after pin wake
    } rsw_state_t;

    // Register file carrier
    typedef struct packed {
        logic [7:0] status;   // Status register
        logic [7:0] ramsel;   // RAM select register
        logic [7:0] control;  // Control options register
        logic [7:0] p6wake;   // Port6 wake disable register
        logic [7:0] slpwdt;   // Sleep/watchdog control register
        logic [7:0] intflag;  // Interrupt flag register
        logic [7:0] intmask;  // Interrupt mask register
    } rsw_regs_t;

    // Wishbone request carrier
    typedef struct packed {
        logic       cyc;  // Cycle
        logic       stb;  // Strobe
        logic       we;   // Write enable
        logic [3:0] sel;  // Byte selects
        logic [7:0] adr;  // Byte address
        logic [31:0] dat; // Write data
    } rsw_wb_req_t;

endpackage : rsw_pkg

// File: rsw_tick_counter.sv
// Divider and counter timing the hold from the watchdog RC tick
`timescale 1ns/1ps
module rsw_tick_counter
    import rsw_pkg::*;
#(
    parameter int DIV   = RSW_RC_DIV,    // Clocks per RC tick
    parameter int TICKS = RSW_OST_TICKS  // RC ticks per hold period
)(
    input  wire logic clk_i,    // Core clock
    input  wire logic rst_i,    // Synchronous reset
    input  wire logic clear_i,  // Restart the count
    output logic      tick_o,   // One RC tick pulse
    output logic      done_o    // Hold count reached (level)
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [15:0] div;  // Clock divider
        logic [31:0] cnt;  // Tick count
        logic        tick; // Tick pulse
        logic        done; // Count complete
    } rsw_tc_t;

    rsw_tc_t st_reg;   // Registered state
    rsw_tc_t st_next;  // Next state

    // Divider runs free, like the RC oscillator; counter restarts on clear
    always_comb
    begin
        st_next      = st_reg;
        st_next.tick = 1'b0;
        if (st_reg.div >= 16'(DIV - 1))
        begin
            st_next.div  = 16'h0000;
            st_next.tick = 1'b1;
        end
        else
        begin
            st_next.div = st_reg.div + 16'h0001;
        end
        if (clear_i)
        begin
            st_next.cnt  = 32'h0000_0000;
            st_next.done = 1'b0;
        end
        else if (st_reg.tick && !st_reg.done)
        begin
            st_next.cnt = st_reg.cnt + 32'h0000_0001;
            // Done only once the full hold has elapsed
            if (st_reg.cnt >= 32'(TICKS - 1))
                st_next.done = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign tick_o = st_reg.tick;
    assign done_o = st_reg.done;
endmodule : rsw_tick_counter

// File: rsw_watchdog.sv
// Watchdog counter with shared prescaler, timed by the RC tick
`timescale 1ns/1ps
module rsw_watchdog
    import rsw_pkg::*;
#(
    parameter int TIMEOUT = RSW_OST_TICKS  // Ticks per unscaled timeout
)(
    input  wire logic       clk_i,     // Core clock
    input  wire logic       rst_i,     // Synchronous reset
    input  wire logic       clear_i,   // Clear counter and prescaler
    input  wire logic       enable_i,  // Watchdog enabled
    input  wire logic       tick_i,    // RC tick
    input  wire logic [2:0] ratio_i,   // Prescale select, 0 means 1:1
    input  wire logic       psa_i,     // Prescaler assigned to watchdog
    output logic            timeout_o  // Timeout pulse
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [7:0]  pre;  // Shared prescaler
        logic [31:0] cnt;  // Watchdog count
        logic        to;   // Timeout pulse
    } rsw_wd_t;

    rsw_wd_t st_reg;   // Registered state
    rsw_wd_t st_next;  // Next state
    logic    step;     // Watchdog advance

    // Prescaler divides ticks by 2^ratio when assigned
    always_comb
    begin
        st_next    = st_reg;
        st_next.to = 1'b0;
        step       = 1'b0;
        if (clear_i || !enable_i)
        begin
            st_next.pre = 8'h00;
            st_next.cnt = 32'h0000_0000;
        end
        else if (tick_i)
        begin
            st_next.pre = st_reg.pre + 8'h01;
            // Unscaled when not assigned or ratio 1:1
            step = !psa_i || (ratio_i == 3'h0) ||
                   ((st_reg.pre & ((8'h01 << ratio_i) - 8'h01)) == ((8'h01 << ratio_i) - 8'h01));
            if (step)
            begin
                if (st_reg.cnt >= 32'(TIMEOUT - 1))
                begin
                    st_next.cnt = 32'h0000_0000;
                    st_next.to  = 1'b1;
                end
                else
                begin
                    st_next.cnt = st_reg.cnt + 32'h0000_0001;
                end
            end
        end
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign timeout_o = st_reg.to;
endmodule : rsw_watchdog

// File: rsw_sequencer.sv
// Reset and sleep/wake sequencer top: reset sources, hold, sleep modes, registers
`timescale 1ns/1ps
module rsw_sequencer
    import rsw_pkg::*;
#(
    parameter int PORT_W   = 8,              // Port6 wake pins
    parameter int IO_W     = 24,             // Total port pins
    parameter int RC_DIV   = RSW_RC_DIV,     // Clocks per RC tick
    parameter int OST_TICK = RSW_OST_TICKS   // RC ticks per hold
)(
    input  wire logic              clk_i,          // Core clock
    input  wire logic              rst_i,          // Power-on reset
    input  wire logic              reset_n_i,      // External reset pin, active low
    input  wire logic              wd_fuse_i,      // Watchdog option fuse
    input  wire logic [PORT_W-1:0] wake_pin_i,     // Port6 pin levels
    input  wire logic              wb_cyc_i,       // Wishbone cycle
    input  wire logic              wb_stb_i,       // Wishbone strobe
    input  wire logic              wb_we_i,        // Wishbone write
    input  wire logic [3:0]        wb_sel_i,       // Wishbone byte selects
    input  wire logic [7:0]        wb_adr_i,       // Wishbone byte address
    input  wire logic [31:0]       wb_dat_i,       // Wishbone write data
    output logic [31:0]            wb_dat_o,       // Wishbone read data
    output logic                   wb_ack_o,       // Wishbone acknowledge
    output logic                   core_reset_o,   // Core held in reset
    output logic                   osc_run_o,      // Main oscillator enable
    output logic [10:0]            pc_o,           // Program counter load value
    output logic                   pc_load_o,      // Load pulse for program counter
    output logic [IO_W-1:0]        io_dir_in_o     // Port pin direction, 1 is input
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        rsw_state_t      fsm;     // Sequencer state
        rsw_regs_t       regs;    // Register file
        logic [31:0]     rdat;    // Read data
        logic            ack;     // Bus acknowledge
        logic            creset;  // Core reset out
        logic            osc;     // Oscillator enable
        logic [10:0]     pc;      // Program counter value
        logic            pcld;    // Program counter load pulse
        logic [IO_W-1:0] dir;     // Port directions
        logic            hclr;    // Hold counter clear
        logic            wclr;    // Watchdog clear
    } rsw_top_t;

    rsw_top_t    st_reg;    // Registered state
    rsw_top_t    st_next;   // Next state
    rsw_wb_req_t req;       // Bundled bus request
    logic        tick;      // RC tick
    logic        hold_done; // Hold period over
    logic        wd_to;     // Watchdog timeout pulse
    logic        wd_en;     // Watchdog effective enable
    logic        pin_rst;   // External pin reset
    logic        wake_hit;  // Enabled wake pin low
    logic        wr_hit;    // Bus write taken
    logic [7:0]  wbyte;     // Low write byte

    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                   adr: wb_adr_i, dat: wb_dat_i};

    // ************************************************************
    // Timers
    // ************************************************************
    // RC-tick hold timer
    rsw_tick_counter #(
        .DIV   (RC_DIV),
        .TICKS (OST_TICK)
    ) u_hold (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .clear_i (st_reg.hclr),
        .tick_o  (tick),
        .done_o  (hold_done)
    );

    // Fuse 1 keeps the watchdog off whatever the enable bit says
    assign wd_en = !wd_fuse_i && st_reg.regs.slpwdt[RSW_SW_WDTE];

    rsw_watchdog #(
        .TIMEOUT (OST_TICK)
    ) u_wdt (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .clear_i   (st_reg.wclr),
        .enable_i  (wd_en),
        .tick_i    (tick),
        .ratio_i   (st_reg.regs.control[2:0]),
        .psa_i     (st_reg.regs.control[3]),
        .timeout_o (wd_to)
    );

    assign pin_rst = !reset_n_i;
    // a zero bit enables its pin
    assign wake_hit = |(~st_reg.regs.p6wake & ~wake_pin_i);

    // Decode a byte address to a register read value
    function automatic logic [7:0] rsw_read(input rsw_regs_t r, input logic [7:0] a,
                                            input rsw_state_t f, input logic [10:0] pc);
        logic [7:0] v;
        v = 8'h00;
        if (a == RSW_ADDR_STATUS)       v = r.status;
        else if (a == RSW_ADDR_RAMSEL)  v = r.ramsel;
        else if (a == RSW_ADDR_CONTROL) v = r.control;
        else if (a == RSW_ADDR_P6WAKE)  v = r.p6wake;
        else if (a == RSW_ADDR_SLPWDT)  v = r.slpwdt;
        else if (a == RSW_ADDR_INTFLAG) v = r.intflag;
        else if (a == RSW_ADDR_INTMASK) v = r.intmask;
        else if (a == RSW_ADDR_STATE)   v = {f, 2'b00, pc[10:8]};
        return v;
    endfunction : rsw_read

    // Apply the register reset values common to every reset kind
    function automatic rsw_regs_t rsw_reset_regs(input rsw_regs_t r, input logic por,
                                                 input logic to, input logic pd);
        rsw_regs_t n;
        n = r;
        // Power-on path only; pin and watchdog resets pass por low
        if (por)
        begin
            n.status = r.status & RSW_STATUS_POR_MASK;
            n.ramsel = r.ramsel & RSW_RAMSEL_POR_MASK;
        end
        n.status[RSW_ST_TIMEOUT] = to;
        n.status[RSW_ST_PWRDN]   = pd;
        // control all ones but bit 6
        n.control = RSW_CONTROL_RST;
        n.p6wake = RSW_P6WAKE_RST;
        n.slpwdt = (r.slpwdt & RSW_SLPWDT_CLR_MASK) | RSW_SLPWDT_SET_MASK;
        n.intflag = r.intflag & RSW_INT_CLR_MASK;
        n.intmask = r.intmask & RSW_INT_CLR_MASK;
        return n;
    endfunction : rsw_reset_regs

    assign wr_hit = req.cyc && req.stb && req.we && !st_reg.ack && req.sel[0];
    assign wbyte  = req.dat[7:0];

    // ************************************************************
    // Sequencer and register file
    // ************************************************************
    always_comb
    begin
        st_next      = st_reg;
        st_next.pcld = 1'b0;
        st_next.hclr = 1'b0;
        st_next.wclr = 1'b0;
        // Bus: one wait state, ack drops the cycle after
        st_next.ack  = req.cyc && req.stb && !st_reg.ack;
        st_next.rdat = {24'h000000, rsw_read(st_reg.regs, req.adr, st_reg.fsm, st_reg.pc)};
        if (wr_hit && st_reg.fsm == RSW_S_RUN)
        begin
            if (req.adr == RSW_ADDR_STATUS)       st_next.regs.status  = wbyte;
            else if (req.adr == RSW_ADDR_RAMSEL)  st_next.regs.ramsel  = wbyte;
            else if (req.adr == RSW_ADDR_CONTROL) st_next.regs.control = wbyte;
            else if (req.adr == RSW_ADDR_P6WAKE)  st_next.regs.p6wake  = wbyte;
            else if (req.adr == RSW_ADDR_SLPWDT)
            begin
                st_next.regs.slpwdt = wbyte;
                if (!wbyte[RSW_SW_OSCRUN])
                begin
                    st_next.fsm = RSW_S_OSCILLATOR_STOP_RESUME_MODE;
                    st_next.osc = 1'b0;
                end
            end
            else if (req.adr == RSW_ADDR_INTFLAG) st_next.regs.intflag = wbyte;
            else if (req.adr == RSW_ADDR_INTMASK) st_next.regs.intmask = wbyte;
            else if (req.adr == RSW_ADDR_CMD)
            begin
                // sleep op clears watchdog, keeps it counting
                if (wbyte[RSW_CMD_SLEEP])
                begin
                    st_next.wclr = 1'b1;
                    st_next.regs.status[RSW_ST_PWRDN]   = 1'b0;
                    st_next.regs.status[RSW_ST_TIMEOUT] = 1'b1;
                    st_next.fsm = RSW_S_HALT_UNTIL_RESET_MODE;
                end
                else if (wbyte[RSW_CMD_WDCLR])
                    st_next.wclr = 1'b1;
            end
        end
        case (st_reg.fsm)
            RSW_S_HOLD:
            begin
                // stay in reset until the hold expires
                if (pin_rst)
                    st_next.hclr = 1'b1;
                else if (hold_done && !st_reg.hclr)
                begin
                    st_next.fsm    = RSW_S_RUN;
                    st_next.creset = 1'b0;
                end
            end
            RSW_S_OSCILLATOR_STOP_RESUME_MODE:
            begin
                // enabled wake pin low starts restart
                if (wake_hit && !pin_rst && !wd_to)
                begin
                    st_next.osc  = 1'b1;
                    st_next.hclr = 1'b1;
                    st_next.fsm  = RSW_S_OST;
                    // Hardware sets the run bit on wake
                    st_next.regs.slpwdt[RSW_SW_OSCRUN] = 1'b1;
                    st_next.regs.slpwdt[RSW_SW_WDTE] = 1'b1;
                end
            end
            RSW_S_OST:
            begin
                if (hold_done && !st_reg.hclr)
                    st_next.fsm = RSW_S_RUN;
            end
            default:
            begin
            end
        endcase
        // any reset source restarts the hold
        // sleep mode one leaves only this way
        // mode two resets on watchdog or pin
        if (pin_rst || wd_to)
        begin
            st_next.fsm    = RSW_S_HOLD;
            st_next.creset = 1'b1;
            st_next.hclr   = 1'b1;
            st_next.wclr   = 1'b1;
            st_next.osc    = 1'b1;
            st_next.pc     = RSW_PC_RST;
            st_next.pcld   = 1'b1;
            st_next.dir    = '1;
            st_next.regs   = rsw_reset_regs(st_reg.regs, 1'b0,
                                            !wd_to, !(st_reg.fsm == RSW_S_HALT_UNTIL_RESET_MODE || st_reg.fsm == RSW_S_OSCILLATOR_STOP_RESUME_MODE));
        end
    end

    // Power-on reset clears everything to constants, then holds
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_reg        <= '0;
            st_reg.fsm    <= RSW_S_HOLD;
            st_reg.creset <= 1'b1;
            st_reg.osc    <= 1'b1;
            st_reg.pc     <= RSW_PC_RST;
            st_reg.pcld   <= 1'b1;
            st_reg.dir    <= '1;
            st_reg.hclr   <= 1'b1;
            st_reg.wclr   <= 1'b1;
            // power-on clears status 6:5, ramsel 7:6
            st_reg.regs   <= '{status: RSW_STATUS_POR, ramsel: 8'h00, control: RSW_CONTROL_RST,
                               p6wake: RSW_P6WAKE_RST, slpwdt: RSW_SLPWDT_SET_MASK,
                               intflag: 8'h00, intmask: 8'h00};
        end
        else
            st_reg <= st_next;
    end

    // Outputs straight from flops
    assign wb_dat_o     = st_reg.rdat;
    assign wb_ack_o     = st_reg.ack;
    assign core_reset_o = st_reg.creset;
    assign osc_run_o    = st_reg.osc;
    assign pc_o         = st_reg.pc;
    assign pc_load_o    = st_reg.pcld;
    assign io_dir_in_o  = st_reg.dir;
endmodule : rsw_sequencer

// File: rsw_pins.sv
// Far-side model: reset pin and port6 wake pins
`timescale 1ns/1ps
module rsw_pins (
    input  wire logic       rst_cmd_i,  // Bench holds reset pin low
    input  wire logic [7:0] low_cmd_i,  // Bench pulls these pins low
    output logic            reset_n_o,  // Reset pin level
    output logic [7:0]      wake_pin_o  // Wake pin levels
);
    // Released lines float to the pull-up level, never the last value
    assign reset_n_o  = !rst_cmd_i;
    assign wake_pin_o = ~low_cmd_i;
endmodule : rsw_pins

// File: rsw_sva.sv
// Port checks for the reset and sleep/wake sequencer
`timescale 1ns/1ps
module rsw_sva #(parameter int IO_W = 24)(
    input wire logic            clk_i,
    input wire logic            rst_i,
    input wire logic            reset_n_i,
    input wire logic            wb_cyc_i,
    input wire logic            wb_stb_i,
    input wire logic [31:0]     wb_dat_o,
    input wire logic            wb_ack_o,
    input wire logic            core_reset_o,
    input wire logic            osc_run_o,
    input wire logic [10:0]     pc_o,
    input wire logic [IO_W-1:0] io_dir_in_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_pin_low; !reset_n_i; endsequence
    sequence s_pin_free; reset_n_i [*8]; endsequence
    property p_pin_rst; s_pin_low |=> core_reset_o && osc_run_o; endproperty
    a_pin_rst: assert property (p_pin_rst) else $error("pin low did not reset");
    property p_hold_min; s_pin_low |=> core_reset_o [*7]; endproperty
    a_hold_min: assert property (p_hold_min) else $error("hold too short");
    property p_hold_max; s_pin_low ##1 s_pin_free |-> ##[0:24] !core_reset_o; endproperty
    a_hold_max: assert property (p_hold_max) else $error("hold too long");
    property p_pc; core_reset_o |-> pc_o == 11'h7FF; endproperty
    a_pc: assert property (p_pc) else $error("pc not all ones in reset");
    property p_io; &io_dir_in_o; endproperty
    a_io: assert property (p_io) else $error("port pin not input");
    property p_osc; !osc_run_o |-> !core_reset_o; endproperty
    a_osc: assert property (p_osc) else $error("oscillator off in reset");
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_dat_hi; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
    a_dat_hi: assert property (p_dat_hi) else $error("read upper bits set");
endmodule : rsw_sva
bind rsw_sequencer rsw_sva #(.IO_W(IO_W)) u_sva (.clk_i(clk_i), .rst_i(rst_i), .reset_n_i(reset_n_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .core_reset_o(core_reset_o), .osc_run_o(osc_run_o), .pc_o(pc_o), .io_dir_in_o(io_dir_in_o));

// File: tb_top.sv
// Self-checking bench for the reset and sleep/wake sequencer
`timescale 1ns/1ps
module tb_top;
    import rsw_pkg::*;
    logic        clk_i = 0, rst_i = 1, fuse = 1, pin_rst = 0, ack, core_rst, osc, pcld;
    logic [7:0]  low_cmd = 8'h00, q = 8'h00, wpin, m [7], msk [7];
    logic [31:0] rdat;
    logic [10:0] pc;
    logic [23:0] io;
    logic        rst_n;
    rsw_wb_req_t req = '0;                       // Bus request carrier
    int          fails = 0, comparisons = 0, i, k;
    initial forever #2.5 clk_i = ~clk_i;
    rsw_pins PRT (.rst_cmd_i(pin_rst), .low_cmd_i(low_cmd), .reset_n_o(rst_n), .wake_pin_o(wpin));
    // Short hold: 2 clocks per tick, 4 ticks
    rsw_sequencer #(.RC_DIV(2), .OST_TICK(4)) DUT (.clk_i(clk_i), .rst_i(rst_i), .reset_n_i(rst_n),
        .wd_fuse_i(fuse), .wake_pin_i(wpin), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we),
        .wb_sel_i(req.sel), .wb_adr_i(req.adr), .wb_dat_i(req.dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .core_reset_o(core_rst), .osc_run_o(osc), .pc_o(pc), .pc_load_o(pcld), .io_dir_in_o(io));
    task give_verdict;
        $display("Counts: %0d compared, %0d failed", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e)
        begin
            fails++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // Bounded wait for a level; running out ends the run
    task automatic wait_sig(ref logic s, input logic v);
        int n = 0;
        while (s !== v && n < 300)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 300)
        begin
            fails++;
            give_verdict();
        end
    endtask : wait_sig
    // Classic single cycle; request held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, w, 4'h1, a, {24'h0, d}};
        @(posedge clk_i);
        wait_sig(ack, 1'b1);
        q = rdat[7:0];
        req <= '0;
    endtask : wb
    // Model reset: only power-on touches status 6:5 and ramsel 7:6
    task mrst(input bit por, input logic [1:0] tp);
        m[0] = por ? 8'h18 : {m[0][7:5], tp, m[0][2:0]};
        m[1] = por ? 8'h00 : m[1];
        m[2] = 8'hBF;
        m[3] = 8'hFF;
        m[4] = (m[4] & 8'hB7) | 8'h31;
        m[5] = m[5] & 8'hF6;
        m[6] = m[6] & 8'hF6;
    endtask : mrst
    task chk_regs;
        wait_sig(core_rst, 1'b0);
        for (int j = 0; j < 7; j++)
        begin
            wb(0, 8'(j * 4), 8'h00);
            chk("register", q & msk[j], m[j] & msk[j]);
        end
    endtask : chk_regs
    task pin_pulse;
        pin_rst <= 1;
        @(posedge clk_i);
        pin_rst <= 0;
        @(posedge clk_i);
        chk("pc load", pcld, 1);
        @(posedge clk_i);
    endtask : pin_pulse
    initial
    begin
        msk = '{8'h78, 8'hC0, 8'hFF, 8'hFF, 8'h79, 8'h09, 8'h09};
        void'($urandom(32'hCE4EF54E));
        repeat (5) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        chk("pc", pc, 11'h7FF);
        chk("io", io, 24'hFFFFFF);
        mrst(1, 2'b11);
        chk_regs;
        $display("test power-on done");
        for (i = 0; i < 7; i++)
        begin
            m[i] = 8'($urandom) | ((i == 4) ? 8'h10 : 8'h00);
            wb(1, 8'(i * 4), m[i]);
        end
        wb(1, 8'h24, 8'h5A);
        wb(0, 8'h24, 8'h00);
        chk("unmapped", q, 0);
        pin_pulse();
        mrst(0, 2'b11);
        chk_regs;
        $display("test pin reset done");
        fuse <= 0;
        k = $urandom_range(7);
        wb(1, 8'h08, 8'h8F);
        wb(1, 8'h0C, ~(8'h01 << k));
        wb(1, 8'h10, 8'h01);
        repeat (2) @(posedge clk_i);
        chk("osc", osc, 0);
        low_cmd <= ~(8'h01 << k);
        repeat (4) @(posedge clk_i);
        chk("osc", osc, 0);
        low_cmd <= 8'h01 << k;
        wait_sig(osc, 1'b1);
        chk("core", core_rst, 0);
        low_cmd <= 0;
        q = 8'h00;
        for (i = 0; i < 60 && q[7:5] !== 3'b001; i++)
            wb(0, 8'h20, 8'h00);
        chk("state", q[7:5], 1);
        wb(0, 8'h10, 8'h00);
        chk("wdt enable", q & 8'h20, 8'h20);
        wb(1, 8'h0C, 8'hFF);
        wb(1, 8'h10, 8'h11);
        $display("test pin wake done");
        wb(1, 8'h1C, 8'h01);
        repeat (4) @(posedge clk_i);
        chk("core", core_rst, 0);
        pin_pulse();
        mrst(0, 2'b10);
        chk_regs;
        $display("test halt and pin done");
        wb(1, 8'h1C, 8'h02);
        wb(1, 8'h08, 8'h0A);
        wb(1, 8'h1C, 8'h01);
        mrst(0, 2'b00);
        wait_sig(core_rst, 1'b1);
        chk_regs;
        $display("test watchdog done");
        give_verdict();
    end
endmodule : tb_top
